// file: rsfim_params.svh
/*
 * constants for the rail status flag and interrupt mask block:
 * register offsets, field positions and reset values.
 * assumes it is included once by the package and the design file.
 */
`ifndef RSFIM_PARAMS_SVH
`define RSFIM_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RSFIM_OFS_GLOBAL_FLAGS 8'h00
`define RSFIM_OFS_RAIL_FLAGS 8'h01
`define RSFIM_OFS_GLOBAL_UNMASK 8'h02
`define RSFIM_OFS_RAIL_UNMASK 8'h03

// ----------------------------------------
// rail flag fields
// ----------------------------------------
`define RSFIM_RAIL_LOW_LSB 3
`define RSFIM_RAIL_GOOD_LSB 0
`define RSFIM_RAIL_USED_MASK 8'h3f
`define RSFIM_RAIL_FLAGS_RESET 8'h00
`define RSFIM_RAIL_UNMASK_RESET 6'h00

// ----------------------------------------
// global flag fields
// ----------------------------------------
`define RSFIM_GBIT_SUPPLY_LOW 7
`define RSFIM_GBIT_CAL_DONE 6
`define RSFIM_GBIT_CHARGE_OVER 5
`define RSFIM_GBIT_VOLTAGE_FAULT_SUMMARY 4
`define RSFIM_GBIT_TEMP_FAULT 3
`define RSFIM_GBIT_BUS_FAULT 2
`define RSFIM_GBIT_OTP_CRC 1
`define RSFIM_GBIT_OTP_READ 0
`define RSFIM_GLOBAL_UNMASK_RESET 8'h01
`define RSFIM_RDATA_RESET 8'h00

`endif

// file: rsfim_pkg.sv
/*
 * types shared by the rail status flag and interrupt mask block.
 * assumes rsfim_params.svh is on the include path.
 */
package rsfim_pkg;
    `include "rsfim_params.svh"

    // ----------------------------------------
    // register access from the serial slave
    // ----------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rsfim_req_s;

    typedef logic [2:0] rsfim_rail_t;
endpackage

// file: rsfim_top.sv
/*
 * sticky regulation flags for outputs a, b and c, the per-output and
 * global unmask registers, the voltage fault summary flag and the
 * interrupt line.
 * assumes a register request port driven by the serial slave on
 * ref_clk, live regulation levels from the analog outputs (async),
 * and the other global status flags held by same-clock logic.
 */
`timescale 1ns/1ps
`include "rsfim_params.svh"

module rsfim_top
    import rsfim_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire rsfim_req_s reg_req,
    input wire rsfim_rail_t regulating_now,
    input wire logic [7:0] ext_global_flags,
    output logic [7:0] reg_rdata_q,
    output logic [5:0] rail_flags_q,
    output logic voltage_fault_summary_q,
    output logic irq_q
);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    logic wr_rail;
    logic wr_global;
    logic wr_gmask;
    logic wr_rmask;
    assign wr_rail = reg_req.wr && (reg_req.addr == `RSFIM_OFS_RAIL_FLAGS);
    assign wr_global = reg_req.wr && (reg_req.addr == `RSFIM_OFS_GLOBAL_FLAGS);
    assign wr_gmask = reg_req.wr && (reg_req.addr == `RSFIM_OFS_GLOBAL_UNMASK);
    assign wr_rmask = reg_req.wr && (reg_req.addr == `RSFIM_OFS_RAIL_UNMASK);

    // ----------------------------------------
    // live regulation synchroniser
    // ----------------------------------------
    rsfim_rail_t sync1_q;
    rsfim_rail_t sync2_q;
    rsfim_rail_t prev_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            prev_q <= 3'h0;
        end else begin
            sync1_q <= regulating_now;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // ----------------------------------------
    // transition detect per output
    // ----------------------------------------
    logic [5:0] rail_set;
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch++) begin : g_rail
            assign rail_set[`RSFIM_RAIL_LOW_LSB + ch] = prev_q[ch] && !sync2_q[ch];
            assign rail_set[`RSFIM_RAIL_GOOD_LSB + ch] = !prev_q[ch] && sync2_q[ch];
        end
    endgenerate

    // ----------------------------------------
    // sticky rail flags
    // ----------------------------------------
    logic [5:0] rail_clr;
    logic [5:0] rail_flags_d;
    assign rail_clr = wr_rail ? reg_req.wdata[5:0] : 6'h00;
    assign rail_flags_d = (rail_flags_q & ~rail_clr) | rail_set;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rail_flags_q <= 6'h00;
        end else begin
            rail_flags_q <= rail_flags_d;
        end
    end

    // ----------------------------------------
    // unmask registers
    // ----------------------------------------
    logic [7:0] gmask_q;
    logic [5:0] rmask_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gmask_q <= `RSFIM_GLOBAL_UNMASK_RESET;
        end else if (wr_gmask) begin
            gmask_q <= reg_req.wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rmask_q <= `RSFIM_RAIL_UNMASK_RESET;
        end else if (wr_rmask) begin
            rmask_q <= reg_req.wdata[5:0];
        end
    end

    // ----------------------------------------
    // voltage fault summary
    // ----------------------------------------
    logic vfault_set;
    logic vfault_clr;
    assign vfault_set = |(rail_set & rmask_q);
    assign vfault_clr = wr_global && reg_req.wdata[`RSFIM_GBIT_VOLTAGE_FAULT_SUMMARY];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            voltage_fault_summary_q <= 1'b0;
        end else begin
            voltage_fault_summary_q <= vfault_set || (voltage_fault_summary_q && !vfault_clr);
        end
    end

    // ----------------------------------------
    // interrupt line
    // ----------------------------------------
    logic [7:0] global_view;
    logic irq_d;
    always_comb begin
        global_view = ext_global_flags;
        global_view[`RSFIM_GBIT_VOLTAGE_FAULT_SUMMARY] = voltage_fault_summary_q;
    end
    assign irq_d = |(global_view & gmask_q);

    // otp read flag unmasked at reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    logic [7:0] rdata_d;
    always_comb begin
        case (reg_req.addr)
            `RSFIM_OFS_GLOBAL_FLAGS: rdata_d = global_view;
            `RSFIM_OFS_RAIL_FLAGS: rdata_d = {2'b00, rail_flags_q};
            `RSFIM_OFS_GLOBAL_UNMASK: rdata_d = gmask_q;
            `RSFIM_OFS_RAIL_UNMASK: rdata_d = {2'b00, rmask_q};
            default: rdata_d = `RSFIM_RDATA_RESET;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= `RSFIM_RDATA_RESET;
        end else if (reg_req.rd) begin
            reg_rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    generate
        for (ch = 0; ch < 3; ch++) begin : g_chk
            sequence s_drop;
                prev_q[ch] && !sync2_q[ch];
            endsequence
            sequence s_rise;
                !prev_q[ch] && sync2_q[ch];
            endsequence
            a_low_flag_set: assert property (s_drop |=> rail_flags_q[3 + ch])
                else $error("low flag not set after drop");
            a_good_flag_set: assert property (s_rise |=> rail_flags_q[ch])
                else $error("good flag not set after rise");
            a_good_needs_rise: assert property (
                $rose(rail_flags_q[ch]) |-> $past(!prev_q[ch] && sync2_q[ch]))
                else $error("good flag set without rise");
            a_low_needs_drop: assert property (
                $rose(rail_flags_q[3 + ch]) |-> $past(prev_q[ch] && !sync2_q[ch]))
                else $error("low flag set without drop");
        end
    endgenerate

    a_w1c_clears: assert property (
        (wr_rail && reg_req.wdata[0] && !rail_set[0]) |=> !rail_flags_q[0])
        else $error("write one did not clear flag");

    a_zero_keeps: assert property (
        (rail_flags_q[5] && wr_rail && !reg_req.wdata[5]) |=> rail_flags_q[5])
        else $error("write zero cleared flag");

    a_set_beats_clear: assert property (
        (wr_rail && reg_req.wdata[3] && rail_set[3]) |=> rail_flags_q[3])
        else $error("event lost under clear");

    a_reserved_reads_zero: assert property (
        (reg_req.rd && reg_req.addr == `RSFIM_OFS_RAIL_FLAGS) |=> reg_rdata_q[7:6] == 2'b00)
        else $error("reserved bits not zero");

    sequence s_unmasked_rail_event;
        |(rail_set & rmask_q);
    endsequence
    sequence s_summary_raised;
        (voltage_fault_summary_q && !gmask_q[`RSFIM_GBIT_VOLTAGE_FAULT_SUMMARY])
            or (voltage_fault_summary_q && gmask_q[`RSFIM_GBIT_VOLTAGE_FAULT_SUMMARY] ##1 irq_q);
    endsequence
    a_vfault_from_rail: assert property (
        s_unmasked_rail_event |=> s_summary_raised)
        else $error("voltage fault summary missed");

    a_irq_follows: assert property (
        |(global_view & gmask_q) |=> irq_q)
        else $error("interrupt not raised");

    a_irq_drops: assert property (
        !(|(global_view & gmask_q)) |=> !irq_q)
        else $error("interrupt held without flag");

    a_otp_read_irq: assert property (
        (ext_global_flags[0] && gmask_q[0]) ##1 (ext_global_flags[0] && gmask_q[0])
            |-> irq_q)
        else $error("otp read flag did not interrupt");

    a_mask_gates: assert property (
        (ext_global_flags == 8'h80 && !gmask_q[7] && !voltage_fault_summary_q)
            |=> !irq_q)
        else $error("masked supply low raised interrupt");

    // ----------------------------------------
    // reset value checks
    // ----------------------------------------
    a_unmask_reset: assert property (
        $rose(rst_n) |-> (gmask_q == `RSFIM_GLOBAL_UNMASK_RESET
            && rmask_q == `RSFIM_RAIL_UNMASK_RESET))
        else $error("unmask registers not at reset value");

    a_flags_reset: assert property (
        $rose(rst_n) |-> (rail_flags_q == 6'h00 && !voltage_fault_summary_q && !irq_q))
        else $error("flags not cleared by reset");

    // ----------------------------------------
    // write one to clear, per bit
    // ----------------------------------------
    genvar fb;
    generate
        for (fb = 0; fb < 6; fb++) begin : g_clr_chk
            a_clear_needs_one: assert property (
                $fell(rail_flags_q[fb]) |-> $past(wr_rail && reg_req.wdata[fb]))
                else $error("flag cleared without write of one");
        end
    endgenerate

    // ----------------------------------------
    // global unmask gating, per bit
    // ----------------------------------------
    genvar gb;
    generate
        for (gb = 0; gb < 8; gb++) begin : g_gate_chk
            a_lone_masked_quiet: assert property (
                (global_view == (8'h01 << gb) && !gmask_q[gb]) |=> !irq_q)
                else $error("masked global flag raised interrupt");
            a_lone_unmasked_irq: assert property (
                (global_view[gb] && gmask_q[gb]) |=> irq_q)
                else $error("unmasked global flag missed interrupt");
        end
    endgenerate

    // ----------------------------------------
    // voltage fault summary checks
    // ----------------------------------------
    a_vfault_needs_event: assert property (
        $rose(voltage_fault_summary_q) |-> $past(|(rail_set & rmask_q)))
        else $error("summary raised without unmasked event");

    a_vfault_w1c: assert property (
        (vfault_clr && !vfault_set) |=> !voltage_fault_summary_q)
        else $error("summary not cleared by write of one");

    a_vfault_set_wins: assert property (
        (vfault_clr && vfault_set) |=> voltage_fault_summary_q)
        else $error("summary event lost under clear");

    // ----------------------------------------
    // register store and read checks
    // ----------------------------------------
    a_gmask_store: assert property (
        wr_gmask |=> gmask_q == $past(reg_req.wdata))
        else $error("global unmask write not stored");

    a_rmask_store: assert property (
        wr_rmask |=> rmask_q == $past(reg_req.wdata[5:0]))
        else $error("rail unmask write not stored");

    a_rmask_reserved: assert property (
        (reg_req.rd && reg_req.addr == `RSFIM_OFS_RAIL_UNMASK) |=> reg_rdata_q[7:6] == 2'b00)
        else $error("rail unmask reserved bits not zero");

    a_global_read: assert property (
        (reg_req.rd && reg_req.addr == `RSFIM_OFS_GLOBAL_FLAGS)
            |=> reg_rdata_q == $past(global_view))
        else $error("global flag read data wrong");

    a_rail_read: assert property (
        (reg_req.rd && reg_req.addr == `RSFIM_OFS_RAIL_FLAGS)
            |=> reg_rdata_q[5:0] == $past(rail_flags_q))
        else $error("rail flag read data wrong");

endmodule

// file: rsfim_far_model.sv
/*
 * far side model: live rail levels and the other global flags.
 * assumes the bench drives levels on ref_clk, after the rising edge.
 */
`timescale 1ns/1ps
module rsfim_far_model
    import rsfim_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire rsfim_rail_t rail_set,
    input wire logic [7:0] flag_set,
    input wire logic otp_clr,
    output rsfim_rail_t regulating_now,
    output logic [7:0] ext_global_flags
);
    logic otp_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            otp_q <= 1'b0;
        end else begin
            otp_q <= !otp_clr;
        end
    end
    always_ff @(posedge ref_clk) begin
        regulating_now <= rail_set;
    end
    assign ext_global_flags = flag_set | {7'h00, otp_q};
endmodule

// file: rsfim_top_tb.sv
/*
 * self-checking bench for the rail flag and unmask block.
 * assumes rsfim_pkg and rsfim_far_model are compiled first.
 */
`timescale 1ns/1ps
module rsfim_top_tb
    import rsfim_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n;
    logic rd_taken = 1'b0;
    rsfim_req_s reg_req;
    rsfim_rail_t regulating_now, rail_set;
    logic [7:0] ext_global_flags, flag_set, reg_rdata_q, m;
    logic [5:0] rail_flags_q;
    logic voltage_fault_summary_q, irq_q, otp_clr;
    logic [31:0] seed = 32'h0000_0027;
    logic [7:0] exp_q[$];
    int fails = 0;
    int comparisons = 0;

    always #50 ref_clk = ~ref_clk;

    rsfim_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req),
        .regulating_now(regulating_now), .ext_global_flags(ext_global_flags),
        .reg_rdata_q(reg_rdata_q), .rail_flags_q(rail_flags_q),
        .voltage_fault_summary_q(voltage_fault_summary_q), .irq_q(irq_q));
    rsfim_far_model i_far (.ref_clk(ref_clk), .rst_n(rst_n), .rail_set(rail_set),
        .flag_set(flag_set), .otp_clr(otp_clr), .regulating_now(regulating_now),
        .ext_global_flags(ext_global_flags));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            fails++;
            $display("ERROR %0t got %h want %h", $time, seen, want);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        reg_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        reg_req <= '0;
    endtask
    task automatic pin(input logic seen, input logic want);
        @(negedge ref_clk);
        chk({7'h00, seen}, {7'h00, want});
    endtask
    task automatic print_verdict;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // read data monitor
    // ----------------------------------------
    always @(posedge ref_clk) begin
        rd_taken <= reg_req.rd;
    end
    always @(negedge ref_clk) begin
        if (rd_taken === 1'b1 && exp_q.size() > 0) begin
            chk(reg_rdata_q, exp_q.pop_front());
        end
    end

    initial begin
        #200000;
        fails++;
        print_verdict();
    end

    initial begin
        reg_req = '0;
        rail_set = 3'h0;
        flag_set = 8'h00;
        otp_clr = 1'b0;
        rst_n = 1'b0;
        cyc(5);
        rst_n <= 1'b1;
        cyc(6);
        rd(8'h02, 8'h01);
        rd(8'h03, 8'h00);
        rd(8'h01, 8'h00);
        rd(8'h00, 8'h01);
        pin(irq_q, 1'b1);
        wr(8'h07, 8'hff);
        rd(8'h07, 8'h00);
        rail_set <= 3'h7;
        cyc(6);
        rd(8'h01, 8'h07);
        otp_clr <= 1'b1;
        cyc(3);
        pin(irq_q, 1'b0);
        wr(8'h01, 8'h00);
        rd(8'h01, 8'h07);
        wr(8'h01, 8'h07);
        rd(8'h01, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            rail_set <= 3'h7 ^ (3'h1 << i);
            cyc(6);
            rd(8'h01, 8'h08 << i);
            rail_set <= 3'h7;
            cyc(6);
            rd(8'h01, 8'h09 << i);
            @(negedge ref_clk);
            chk({2'b00, rail_flags_q}, 8'h09 << i);
            wr(8'h01, 8'h3f);
            rd(8'h01, 8'h00);
        end
        $display("test rails done");
        wr(8'h03, 8'h3f);
        rd(8'h03, 8'h3f);
        wr(8'h02, 8'h10);
        rail_set <= 3'h6;
        cyc(6);
        pin(voltage_fault_summary_q, 1'b1);
        cyc(2);
        pin(irq_q, 1'b1);
        rd(8'h00, 8'h10);
        rail_set <= 3'h7;
        cyc(6);
        wr(8'h01, 8'h3f);
        wr(8'h00, 8'h10);
        cyc(3);
        pin(irq_q, 1'b0);
        $display("test summary done");
        cyc(1);
        rail_set <= 3'h6;
        cyc(2);
        wr(8'h01, 8'h3f);
        rd(8'h01, 8'h08);
        rail_set <= 3'h7;
        cyc(2);
        wr(8'h00, 8'h10);
        rd(8'h00, 8'h10);
        wr(8'h01, 8'h3f);
        wr(8'h00, 8'h10);
        rd(8'h00, 8'h00);
        $display("test set wins done");
        for (int i = 0; i < 8; i++) begin
            if (i != 4) begin
                seed = xs(seed);
                m = seed[7:0];
                wr(8'h02, m);
                rd(8'h02, m);
                flag_set <= 8'h01 << i;
                cyc(3);
                pin(irq_q, m[i]);
                wr(8'h02, m ^ (8'h01 << i));
                cyc(3);
                pin(irq_q, !m[i]);
                cyc(1);
                flag_set <= 8'h00;
            end
        end
        $display("test unmask done");
        otp_clr <= 1'b0;
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        cyc(6);
        rd(8'h02, 8'h01);
        rd(8'h03, 8'h00);
        rd(8'h01, 8'h07);
        pin(irq_q, 1'b1);
        $display("test second reset done");
        cyc(2);
        print_verdict();
    end
endmodule
